// ===== rtl/debug_uart_status_irq.sv
// Debug UART: registers, status, interrupt mask, serial engine
//
// Notes on behaviour
// - Enable-register ones set mask bits at defined status bits only; zeros change nothing.
// - Disable-register ones clear mask bits; zeros change nothing.
// - Mask register reads one for each enabled source.
// - Enable, disable, mask and status share one bit layout.
// - Receiver ready sets on a new character, clears on read or disable.
// - Transmitter ready is one unless a char waits or transmitter off.
// - Rx transfer end bit mirrors the receive DMA end signal.
// - Tx transfer end bit mirrors the transmit DMA end signal.
// - Overrun flag sticks until the reset-status command.
// - Framing flag sticks until the reset-status command.
// - Parity flag sticks until the reset-status command.
// - Transmitter idle only with holding and shifter empty and enabled.
// - Tx buffer empty bit mirrors the transmit DMA signal.
// - Rx buffer full bit mirrors the receive DMA signal.
// - Debug write bit follows the processor write flag.
// - Debug read bit follows the processor read flag.
// - Receive holding shows last char in bits 7..0, upper bits zero.
// - Written char is sent after the one being shifted.
// - Divisor 0 stops baud, 1 is master clock, else clock/(16*divisor).
// - Reset-status command clears parity, framing and overrun together.
// - Local loopback feeds transmitter to receiver, tx pin held high.
// - Remote loopback ties rx pin to tx pin, engines disabled.
`default_nettype none
module debug_uart_status_irq
  import dbg_uart_pkg::*;
#(
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire reg_req_s bus_req,
  output logic [31:0] rdata,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  input wire dma_flags_s dma_flags,
  input wire logic debug_write_pending,
  input wire logic debug_read_pending,
  output logic irq
);

  function automatic logic [CNT_W-1:0] bit_len(input logic [15:0] div);
    if (div == 16'h0001) begin
      bit_len = CNT_W'(1);
    end else begin
      bit_len = CNT_W'(div * OVERSAMPLE);
    end
  endfunction : bit_len

  logic [1:0] chan_mode_q;
  logic [15:0] divisor_q;
  logic [31:0] mask_q;
  logic rx_en_q, rx_stop_q, tx_en_q, tx_stop_q;
  logic [7:0] thr_q, rhr_q;
  logic thr_full_q, rx_ready_q, overrun_q, frame_q, par_err_q;
  logic [2:0] rx_s_q;
  logic rx_pin_q, tx_line_q, tx_pin_q, irq_q;
  logic [31:0] rdata_q;
  ser_st_e rx_st_q, rx_st_d, tx_st_q, tx_st_d;
  logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
  logic [8:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
  logic [3:0] rx_n_q, rx_n_d, tx_n_q, tx_n_d;
  logic tx_line_d, thr_take, rx_done, rx_ferr, rx_perr;
  logic [31:0] stat, rd_mux;

  // Register decode
  wire logic wr_ctrl = bus_req.wr && bus_req.addr == OFF_CTRL;
  wire logic wr_mode = bus_req.wr && bus_req.addr == OFF_MODE;
  wire logic wr_ien = bus_req.wr && bus_req.addr == OFF_IEN;
  wire logic wr_idis = bus_req.wr && bus_req.addr == OFF_IDIS;
  wire logic wr_thr = bus_req.wr && bus_req.addr == OFF_TXH;
  wire logic wr_baud = bus_req.wr && bus_req.addr == OFF_BAUD;
  wire logic rd_rhr = bus_req.rd && bus_req.addr == OFF_RXH;
  wire logic [31:0] cw = bus_req.wdata;

  wire logic rst_rx = wr_ctrl && cw[C_RSTRX];
  wire logic rst_tx = wr_ctrl && cw[C_RSTTX];
  wire logic rx_on = wr_ctrl && cw[C_RXEN] && !cw[C_RXDIS];
  wire logic rx_off = wr_ctrl && cw[C_RXDIS];
  wire logic tx_on = wr_ctrl && cw[C_TXEN] && !cw[C_TXDIS];
  wire logic tx_off = wr_ctrl && cw[C_TXDIS];
  wire logic clr_status = wr_ctrl && cw[C_CLR_STATUS];

  // Baud and channel mode
  wire logic baud_on = divisor_q != BAUD_RST;
  wire logic remote = chan_mode_q == CH_REMOTE;
  wire logic [CNT_W-1:0] len = bit_len(divisor_q);
  wire logic [CNT_W-1:0] len_m1 = len - CNT_W'(1);
  wire logic [CNT_W-1:0] half = len >> 1;
  wire logic rx_act = rx_en_q && baud_on && !remote;
  wire logic tx_act = tx_en_q && baud_on && !remote;
  wire logic rx_in = (chan_mode_q == CH_LOCAL) ? tx_line_q : rx_pin_q;
  wire logic rx_tick = rx_cnt_q == '0;
  wire logic tx_tick = tx_cnt_q == '0;
  wire logic tx_busy = tx_st_q != S_IDLE;

  // Disable lets the current work finish before the engine stops
  wire logic rx_en_d = rst_rx ? 1'b0 : rx_on ? 1'b1 :
                       (rx_stop_q && rx_st_q == S_IDLE) ? 1'b0 : rx_en_q;
  wire logic rx_stop_d = (!rx_en_d || rx_on) ? 1'b0 : rx_off ? 1'b1 : rx_stop_q;
  wire logic tx_en_d = rst_tx ? 1'b0 : tx_on ? 1'b1 :
                       (tx_stop_q && !tx_busy && !thr_full_q) ? 1'b0 : tx_en_q;
  wire logic tx_stop_d = (!tx_en_d || tx_on) ? 1'b0 : tx_off ? 1'b1 : tx_stop_q;

  // Receive engine: 8 data bits then parity, then stop
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_tick ? len_m1 : rx_cnt_q - CNT_W'(1);
    rx_sh_d = rx_sh_q;
    rx_n_d = rx_n_q;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    rx_perr = 1'b0;
    if (!rx_act || rst_rx) begin
      rx_st_d = S_IDLE;
    end else begin
      case (rx_st_q)
        S_IDLE: begin
          if (!rx_in) begin
            // One clock a bit: the detecting cycle is already the start bit
            rx_st_d = (len_m1 == '0) ? S_DATA : S_START;
            rx_cnt_d = half;
            rx_n_d = 4'h0;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_st_d = rx_in ? S_IDLE : S_DATA;
            rx_n_d = 4'h0;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_sh_d = {rx_in, rx_sh_q[8:1]};
            rx_n_d = rx_n_q + 4'h1;
            if (rx_n_q == 4'h8) begin
              rx_st_d = S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_st_d = S_IDLE;
            rx_done = 1'b1;
            rx_ferr = !rx_in;
            rx_perr = (^rx_sh_q) ^ PARITY_ODD;
          end
        end
        default: begin
          rx_st_d = S_IDLE;
        end
      endcase
    end
  end

  // Transmit engine; the holding char loads only when the shifter is idle
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_tick ? len_m1 : tx_cnt_q - CNT_W'(1);
    tx_sh_d = tx_sh_q;
    tx_n_d = tx_n_q;
    tx_line_d = tx_line_q;
    thr_take = 1'b0;
    if (rst_tx || !tx_act) begin
      tx_st_d = S_IDLE;
      tx_line_d = 1'b1;
    end else begin
      case (tx_st_q)
        S_IDLE: begin
          if (thr_full_q) begin
            thr_take = 1'b1;
            tx_sh_d = {(^thr_q) ^ PARITY_ODD, thr_q};
            tx_st_d = S_START;
            tx_cnt_d = len_m1;
            tx_line_d = 1'b0;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_st_d = S_DATA;
            tx_line_d = tx_sh_q[0];
            tx_sh_d = tx_sh_q >> 1;
            tx_n_d = 4'h0;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            if (tx_n_q == 4'h8) begin
              tx_st_d = S_STOP;
              tx_line_d = 1'b1;
            end else begin
              tx_line_d = tx_sh_q[0];
              tx_sh_d = tx_sh_q >> 1;
              tx_n_d = tx_n_q + 4'h1;
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_st_d = S_IDLE;
          end
        end
        default: begin
          tx_st_d = S_IDLE;
        end
      endcase
    end
  end

  // Flag updates: a setting event wins over a same-cycle clear
  wire logic ovr_ev = rx_done && rx_ready_q && !rd_rhr;
  wire logic rx_ready_d = rx_done || (rx_ready_q && !rd_rhr && rx_en_q);
  wire logic overrun_d = ovr_ev || (overrun_q && !clr_status);
  wire logic frame_d = (rx_done && rx_ferr) || (frame_q && !clr_status);
  wire logic par_err_d = (rx_done && rx_perr) || (par_err_q && !clr_status);
  wire logic thr_full_d = !rst_tx && (wr_thr || (thr_full_q && !thr_take));
  wire logic [31:0] ien_bits = wr_ien ? (cw & IRQ_VALID) : '0;
  wire logic [31:0] idis_bits = wr_idis ? cw : '0;
  wire logic [31:0] mask_d = (mask_q | ien_bits) & ~idis_bits;

  // Status word, common layout with the mask
  always_comb begin
    stat = '0;
    stat[B_RX_READY] = rx_ready_q;
    stat[B_TX_READY] = tx_en_q && !thr_full_q;
    stat[B_RXEND] = dma_flags.rx_end;
    stat[B_TXEND] = dma_flags.tx_end;
    stat[B_OVRN] = overrun_q;
    stat[B_FRAM] = frame_q;
    stat[B_PERR] = par_err_q;
    stat[B_TXIDLE] = tx_en_q && !thr_full_q && !tx_busy;
    stat[B_TX_BUF_EMPTY] = dma_flags.tx_buf_empty;
    stat[B_RX_BUF_FULL] = dma_flags.rx_buf_full;
    stat[B_DBGW] = debug_write_pending;
    stat[B_DBGR] = debug_read_pending;
  end

  // Read data; unmapped and write-only offsets read zero
  always_comb begin
    case (bus_req.addr)
      OFF_MODE: rd_mux = 32'(chan_mode_q) << MODE_LSB;
      OFF_IMASK: rd_mux = mask_q;
      OFF_STAT: rd_mux = stat;
      OFF_RXH: rd_mux = {24'h000000, rhr_q};
      OFF_BAUD: rd_mux = {16'h0000, divisor_q};
      default: rd_mux = '0;
    endcase
  end

  // Echo and remote copy the filtered rx level; local idles high
  wire logic tx_pin_d = (chan_mode_q == CH_NORMAL) ? tx_line_q :
                        (chan_mode_q == CH_LOCAL) ? 1'b1 : rx_pin_q;
  wire logic rx_pin_d = (rx_s_q[1] == rx_s_q[2]) ? rx_s_q[2] : rx_pin_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_mode_q <= MODE_RST;
      divisor_q <= BAUD_RST;
      mask_q <= MASK_RST;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      chan_mode_q <= wr_mode ? cw[MODE_LSB+1:MODE_LSB] : chan_mode_q;
      divisor_q <= wr_baud ? cw[15:0] : divisor_q;
      mask_q <= mask_d;
      rdata_q <= bus_req.rd ? rd_mux : '0;
      irq_q <= |(stat & mask_q);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_en_q <= 1'b0;
      rx_stop_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_stop_q <= 1'b0;
      rx_ready_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_q <= 1'b0;
      par_err_q <= 1'b0;
      thr_full_q <= 1'b0;
    end else begin
      rx_en_q <= rx_en_d;
      rx_stop_q <= rx_stop_d;
      tx_en_q <= tx_en_d;
      tx_stop_q <= tx_stop_d;
      rx_ready_q <= rx_ready_d;
      overrun_q <= overrun_d;
      frame_q <= frame_d;
      par_err_q <= par_err_d;
      thr_full_q <= thr_full_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thr_q <= 8'h00;
      rhr_q <= 8'h00;
      rx_s_q <= 3'h7;
      rx_pin_q <= 1'b1;
      tx_line_q <= 1'b1;
      tx_pin_q <= 1'b1;
    end else begin
      thr_q <= wr_thr ? cw[7:0] : thr_q;
      rhr_q <= rx_done ? rx_sh_q[7:0] : rhr_q;
      rx_s_q <= {rx_s_q[1:0], serial_rx_pin};
      rx_pin_q <= rx_pin_d;
      tx_line_q <= tx_line_d;
      tx_pin_q <= tx_pin_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q <= S_IDLE;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
      rx_n_q <= 4'h0;
      tx_st_q <= S_IDLE;
      tx_cnt_q <= '0;
      tx_sh_q <= '0;
      tx_n_q <= 4'h0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_n_q <= rx_n_d;
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_sh_q <= tx_sh_d;
      tx_n_q <= tx_n_d;
    end
  end

  assign rdata = rdata_q;
  assign serial_tx_pin = tx_pin_q;
  assign irq = irq_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_ien_sets;
    wr_ien |=> ((mask_q & $past(cw) & IRQ_VALID) == ($past(cw) & IRQ_VALID));
  endproperty
  a_ien_sets: assert property (p_ien_sets) else $error("enable write did not set mask");
  property p_idis_clears;
    wr_idis |=> ((mask_q & $past(cw)) == 32'h0000_0000);
  endproperty
  a_idis_clears: assert property (p_idis_clears) else $error("disable write did not clear mask");
  property p_imask_read;
    bus_req.rd && bus_req.addr == OFF_IMASK |=> rdata == $past(mask_q);
  endproperty
  a_imask_read: assert property (p_imask_read) else $error("mask read mismatch");
  property p_rhr_read_clears;
    rd_rhr && !rx_done |=> !rx_ready_q ##0 !stat[B_RX_READY];
  endproperty
  a_rhr_read_clears: assert property (p_rhr_read_clears) else $error("read did not clear ready");
  property p_thr_write_busy;
    wr_thr && tx_en_q && !rst_tx |=> !stat[B_TX_READY] ##0 !stat[B_TXIDLE];
  endproperty
  a_thr_write_busy: assert property (p_thr_write_busy) else $error("ready high after write");
  property p_err_sticky;
    overrun_q && !clr_status |=> overrun_q;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("overrun flag lost");
  property p_status_clr;
    clr_status && !rx_done |=> !overrun_q && !frame_q && !par_err_q;
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status reset failed");
  property p_irq_follows;
    |(stat & mask_q) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");
  property p_rhr_upper;
    rd_rhr |=> rdata[31:8] == 24'h000000 ##0 rdata[7:0] == $past(rhr_q);
  endproperty
  a_rhr_upper: assert property (p_rhr_upper) else $error("holding read wrong");
  property p_dma_mirror;
    bus_req.rd && bus_req.addr == OFF_STAT |=>
      rdata[B_RXEND] == $past(dma_flags.rx_end) && rdata[B_TXEND] == $past(dma_flags.tx_end);
  endproperty
  a_dma_mirror: assert property (p_dma_mirror) else $error("dma end bits wrong");
  property p_local_high;
    chan_mode_q == CH_LOCAL && $past(chan_mode_q) == CH_LOCAL |-> serial_tx_pin;
  endproperty
  a_local_high: assert property (p_local_high) else $error("tx pin low in local loop");
  property p_remote_idle;
    remote |=> rx_st_q == S_IDLE && tx_st_q == S_IDLE;
  endproperty
  a_remote_idle: assert property (p_remote_idle) else $error("engine active in remote loop");

endmodule : debug_uart_status_irq
`default_nettype wire

// ===== rtl/dbg_uart_pkg.sv
// Constants and types shared by the debug UART block
`default_nettype none
package dbg_uart_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IEN = 8'h08;
  localparam logic [7:0] OFF_IDIS = 8'h0C;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_RXH = 8'h18;
  localparam logic [7:0] OFF_TXH = 8'h1C;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam int B_RX_READY = 0;
  localparam int B_TX_READY = 1;
  localparam int B_RXEND = 3;
  localparam int B_TXEND = 4;
  localparam int B_OVRN = 5;
  localparam int B_FRAM = 6;
  localparam int B_PERR = 7;
  localparam int B_TXIDLE = 9;
  localparam int B_TX_BUF_EMPTY = 11;
  localparam int B_RX_BUF_FULL = 12;
  localparam int B_DBGW = 30;
  localparam int B_DBGR = 31;
  localparam logic [31:0] IRQ_VALID = 32'hC0001AFB;
  localparam int C_RSTRX = 2;
  localparam int C_RSTTX = 3;
  localparam int C_RXEN = 4;
  localparam int C_RXDIS = 5;
  localparam int C_TXEN = 6;
  localparam int C_TXDIS = 7;
  localparam int C_CLR_STATUS = 8;
  localparam int MODE_LSB = 14;
  localparam logic [1:0] CH_NORMAL = 2'h0;
  localparam logic [1:0] CH_ECHO = 2'h1;
  localparam logic [1:0] CH_LOCAL = 2'h2;
  localparam logic [1:0] CH_REMOTE = 2'h3;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int OVERSAMPLE = 16;
  localparam int CNT_W = 20;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_START = 5'h02,
    S_DATA = 5'h04,
    S_PAR = 5'h08,
    S_STOP = 5'h10
  } ser_st_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic rx_end;
    logic tx_end;
    logic tx_buf_empty;
    logic rx_buf_full;
  } dma_flags_s;
endpackage : dbg_uart_pkg
`default_nettype wire

// ===== verification/uart_term.sv
// Serial terminal model on the far side of the debug UART
`default_nettype none
module uart_term #(
  parameter int BIT_CLKS = 32
) (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  int frames = 0;
  // Line has a pull-up, so idle and released both read high
  initial rx_line = 1'b1;
  // Even parity; err 1 flips the parity bit, err 2 drops the stop bit
  task automatic send(input logic [7:0] ch, input int err);
    logic [10:0] fr;
    fr = {1'(err != 2), 1'(^ch ^ (err == 1)), ch, 1'b0};
    @(posedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      rx_line <= fr[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge sys_clk);
  endtask : send
  // Samples mid-bit; parity is skipped, order is LSB first
  always begin
    @(negedge tx_line);
    frames++;
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      if (i < 8) sh[i] = tx_line;
    end
    got_q.push_back(sh);
    repeat (BIT_CLKS) @(posedge sys_clk);
  end
endmodule : uart_term
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking testbench for the debug UART register block
`default_nettype none
module tb_top
  import dbg_uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic sys_rst;
  reg_req_s bus_req;
  logic [31:0] rdata;
  logic rx_pin;
  logic tx_pin;
  dma_flags_s dma_flags;
  logic dbg_w;
  logic dbg_r;
  logic irq;
  logic [31:0] rv;
  int n_fail = 0;
  int n_compared = 0;
  int n0;
  int bpos[6] = '{B_RX_BUF_FULL, B_TX_BUF_EMPTY, B_TXEND, B_RXEND, B_DBGW, B_DBGR};

  debug_uart_status_irq dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
    .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin), .dma_flags(dma_flags),
    .debug_write_pending(dbg_w), .debug_read_pending(dbg_r), .irq(irq)
  );
  // Divisor 2 gives 32 clocks a bit
  uart_term #(.BIT_CLKS(32)) term_u (.sys_clk(sys_clk), .tx_line(tx_pin), .rx_line(rx_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    rd(a);
    check(rv & m, e, what);
  endtask : chk

  task automatic wait_got(input int n);
    for (int k = 0; k < 3000 && term_u.got_q.size() < n; k++) @(posedge sys_clk);
    check(32'(term_u.got_q.size()), 32'(n), "frame count");
  endtask : wait_got

  // Whole run is well under 10000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    dma_flags = '0;
    dbg_w = 1'b0;
    dbg_r = 1'b0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr(OFF_IMASK, 32'hFFFF_FFFF);
    chk(OFF_IMASK, 32'hFFFF_FFFF, 32'h0, "mask reset, read-only");
    chk(OFF_BAUD, 32'hFFFF_FFFF, 32'h0, "divisor reset");
    chk(OFF_MODE, 32'hFFFF_FFFF, 32'h0, "mode reset");
    chk(8'h24, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(OFF_IEN, 32'hFFFF_FFFF);
    chk(OFF_IMASK, 32'hFFFF_FFFF, IRQ_VALID, "enable all");
    wr(OFF_IEN, 32'h0);
    wr(OFF_IDIS, 32'h0);
    chk(OFF_IMASK, 32'hFFFF_FFFF, IRQ_VALID, "zero writes");
    wr(OFF_IDIS, 32'h4000_0081);
    chk(OFF_IMASK, 32'hFFFF_FFFF, IRQ_VALID & ~32'h4000_0081, "partial disable");
    wr(OFF_IDIS, 32'hFFFF_FFFF);
    chk(OFF_IMASK, 32'hFFFF_FFFF, 32'h0, "disable all");
    // Engines are off, so only the mirrored bit may show
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      {dbg_r, dbg_w, dma_flags} <= 6'(1 << i);
      chk(OFF_STAT, 32'hFFFF_FFFF, 32'h1 << bpos[i], "mirror bit");
    end
    repeat (3) @(posedge sys_clk);
    #1 check(32'(irq), 32'h0, "irq while masked");
    wr(OFF_IEN, 32'h1 << B_DBGR);
    repeat (3) @(posedge sys_clk);
    #1 check(32'(irq), 32'h1, "irq on");
    @(posedge sys_clk);
    dbg_r <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(32'(irq), 32'h0, "irq off");
    wr(OFF_IDIS, 32'hFFFF_FFFF);
    wr(OFF_BAUD, 32'h0000_0002);
    chk(OFF_BAUD, 32'hFFFF_FFFF, 32'h2, "divisor");
    wr(OFF_CTRL, (32'h1 << C_RXEN) | (32'h1 << C_TXEN));
    chk(OFF_STAT, 32'hFFFF_FFFF, 32'h202, "tx ready and idle");
    wr(OFF_TXH, 32'hA5);
    wr(OFF_TXH, 32'h3C);
    chk(OFF_STAT, 32'h203, 32'h0, "char waiting");
    wait_got(2);
    check(32'(term_u.got_q[0]), 32'hA5, "first char");
    check(32'(term_u.got_q[1]), 32'h3C, "second char");
    repeat (64) @(posedge sys_clk);
    chk(OFF_STAT, 32'h203, 32'h202, "tx drained");
    term_u.send(8'h5A, 0);
    repeat (40) @(posedge sys_clk);
    chk(OFF_STAT, 32'h1, 32'h1, "rx ready");
    chk(OFF_RXH, 32'hFFFF_FFFF, 32'h5A, "rx char");
    chk(OFF_STAT, 32'h1, 32'h0, "rx ready cleared by read");
    // Two unread chars overrun; then bad parity and a missing stop
    term_u.send(8'h11, 0);
    term_u.send(8'h22, 0);
    term_u.send(8'h33, 1);
    term_u.send(8'h44, 2);
    repeat (40) @(posedge sys_clk);
    chk(OFF_STAT, 32'hE0, 32'hE0, "sticky errors");
    wr(OFF_CTRL, 32'h1 << C_RXDIS);
    // Receiver stops one edge after the disable, ready drops one edge later
    repeat (2) @(posedge sys_clk);
    chk(OFF_STAT, 32'hE1, 32'hE0, "rx off clears ready");
    wr(OFF_CTRL, 32'h1 << C_CLR_STATUS);
    chk(OFF_STAT, 32'hE0, 32'h0, "status reset");
    wr(OFF_CTRL, 32'h1 << C_RXEN);
    wr(OFF_MODE, 32'(CH_LOCAL) << MODE_LSB);
    chk(OFF_MODE, 32'hFFFF_FFFF, 32'(CH_LOCAL) << MODE_LSB, "mode readback");
    n0 = term_u.frames;
    wr(OFF_TXH, 32'h81);
    repeat (450) @(posedge sys_clk);
    check(32'(term_u.frames), 32'(n0), "tx pin quiet in loopback");
    chk(OFF_RXH, 32'hFFFF_FFFF, 32'h81, "looped char");
    // Divisor 1: a whole frame fits in a few clocks
    wr(OFF_BAUD, 32'h1);
    wr(OFF_TXH, 32'h96);
    repeat (20) @(posedge sys_clk);
    chk(OFF_RXH, 32'hFFFF_FFFF, 32'h96, "divisor one");
    wr(OFF_BAUD, 32'h2);
    // Echo keeps the receiver, remote loopback disables it
    for (int m = 0; m < 2; m++) begin
      wr(OFF_MODE, 32'(m ? CH_REMOTE : CH_ECHO) << MODE_LSB);
      rd(OFF_RXH);
      n0 = term_u.got_q.size();
      term_u.send(8'hC3 ^ 8'(m), 0);
      wait_got(n0 + 1);
      check(32'(term_u.got_q[n0]), 32'hC3 ^ 32'(m), "echoed char");
      repeat (64) @(posedge sys_clk);
      chk(OFF_STAT, 32'h1, 32'(m == 0), "receiver in echo modes");
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
